/* shared/elr_pkg.sv */
// package: constants of the event link router and pin interrupt front end
package elr_pkg;
	localparam int DATA_W   = 8;
	localparam int ADDR_W   = 6;
	localparam int N_SRC    = 26;
	localparam int N_PIN    = 6;
	localparam int N_ONCHIP = N_SRC - N_PIN;
	localparam int N_DEST   = 9;
	localparam int N_STS    = 3;
	localparam int CODE_W   = 4;

	// register offsets
	localparam logic [ADDR_W-1:0] OFS_SEL_BASE = 6'h00;
	localparam logic [ADDR_W-1:0] OFS_MASK     = 6'h20;
	localparam logic [ADDR_W-1:0] OFS_REQ      = 6'h21;
	localparam logic [ADDR_W-1:0] OFS_PRIO1    = 6'h22;
	localparam logic [ADDR_W-1:0] OFS_PRIO0    = 6'h23;
	localparam logic [ADDR_W-1:0] OFS_RISE     = 6'h24;
	localparam logic [ADDR_W-1:0] OFS_FALL     = 6'h25;
	localparam logic [ADDR_W-1:0] OFS_STS      = 6'h28;
	localparam logic [ADDR_W-1:0] OFS_CLR      = 6'h29;
	localparam logic [ADDR_W-1:0] OFS_IEN      = 6'h2A;

	// field positions
	localparam int PIN_BIT0     = 2;
	localparam int STS_PIN_EDGE = 0;
	localparam int STS_FORWARD  = 1;
	localparam int STS_DROP     = 2;
	localparam int SEL_TAU1_LO  = 20;
	localparam int SEL_CMP_LO   = 24;

	// reset values
	localparam logic [DATA_W-1:0] RST_MASK = 8'hFF;
	localparam logic [DATA_W-1:0] RST_REQ  = 8'h00;
	localparam logic [DATA_W-1:0] RST_PRIO = 8'hFF;
	localparam logic [DATA_W-1:0] RST_EDGE = 8'h00;
	localparam logic [CODE_W-1:0] RST_SEL  = 4'h0;
	localparam logic [N_STS-1:0]  RST_STS  = 3'h0;

	// destination codes
	localparam logic [CODE_W-1:0] DST_OFF   = 4'h0;
	localparam logic [CODE_W-1:0] DST_ADC   = 4'h1;
	localparam logic [CODE_W-1:0] DST_TIMER_ARRAY_UNIT  = 4'h2;
	localparam logic [CODE_W-1:0] DST_TAU1  = 4'h3;
	localparam logic [CODE_W-1:0] DST_RLD   = 4'h4;
	localparam logic [CODE_W-1:0] DST_GEN   = 4'h5;
	localparam logic [CODE_W-1:0] DST_MFT0  = 4'h6;
	localparam logic [CODE_W-1:0] DST_MFT1  = 4'h7;
	localparam logic [CODE_W-1:0] DST_DAC0  = 4'h8;
	localparam logic [CODE_W-1:0] DST_DAC1  = 4'h9;
endpackage

/* core/elr_router.sv */
// event link router with external pin interrupt front end and register port
`timescale 1ns/1ps

// Summary of operation
// RULE1: pin mask 0 services, 1 blocks request
// RULE2: pin request flag set by edge, write clears
// RULE3: two-bit priority from two registers, 00 highest
// RULE4: rising and falling enables choose valid edges
// RULE5: four-bit route code per source, zero disables
// RULE6: nonzero code picks destination, read/write field
// RULE7: upper four select bits reserved, read zero
// RULE8: sources 00-05 pins, 06 key, 07 rtc
// RULE9: 08-15 other timers, 16-19 array channels
// RULE10: sources 20-23 and code bit3 large package only
// RULE11: sources 24-25 comparators, large flash only
// RULE12: code 0001 starts one conversion
// RULE13: codes 0010/0011 feed array channel 0/1
// RULE14: 0100 reload timer, 0101 general timer capture
// RULE15: 0110/0111 multi-function timer capture and cutoff
// RULE16: 1000/1001 dac real-time trigger, large flash
// RULE17: software chains pin to timer to converter
// RULE18: software masks, clears, level 3, rising first
// RULE19: one-clock pulse, none for off/unimplemented code
module elr_router #(
	parameter bit BIG_PKG   = 1'b1,
	parameter bit BIG_FLASH = 1'b1
) (
	input  wire logic                                CLK_I,
	input  wire logic                                RSTN_I,
	input  wire logic [elr_pkg::ADDR_W-1:0]          ADDR_I,
	input  wire logic [elr_pkg::DATA_W-1:0]          WDATA_I,
	input  wire logic                                WR_I,
	input  wire logic                                RD_I,
	output logic      [elr_pkg::DATA_W-1:0]          RDATA_O,
	input  wire logic [elr_pkg::N_PIN-1:0]           EXT_PIN_I,
	input  wire logic [elr_pkg::N_ONCHIP-1:0]        ONCHIP_EVT_I,
	output logic      [elr_pkg::N_DEST-1:0]          DEST_EVT_O,
	output logic      [elr_pkg::N_PIN-1:0]           PIN_IRQ_O,
	output logic      [2*elr_pkg::N_PIN-1:0]         PIN_PRIO_O,
	output logic                                     IRQ_O
);
	import elr_pkg::*;

	// destination codes 1000/1001 exist only with the large flash option
	function automatic logic code_valid(input logic [CODE_W-1:0] c);
		code_valid = ((c >= DST_ADC) && (c <= DST_MFT1)) ||
			(BIG_FLASH && ((c == DST_DAC0) || (c == DST_DAC1)));
	endfunction

	function automatic logic hit(input logic [ADDR_W-1:0] ofs);
		hit = (ADDR_I == ofs);
	endfunction

	logic [CODE_W-1:0] sel_ff [N_SRC];
	logic [DATA_W-1:0] mask_ff;
	logic [DATA_W-1:0] req_ff;
	logic [DATA_W-1:0] prio1_ff;
	logic [DATA_W-1:0] prio0_ff;
	logic [DATA_W-1:0] rise_en_ff;
	logic [DATA_W-1:0] fall_en_ff;
	logic [N_STS-1:0]  sts_ff;
	logic [N_STS-1:0]  ien_ff;
	logic [N_PIN-1:0]  s1_ff;
	logic [N_PIN-1:0]  s2_ff;
	logic [N_PIN-1:0]  s3_ff;
	logic [N_PIN-1:0]  lvl_ff;
	logic              primed_ff;
	logic [DATA_W-1:0] rdata_ff;
	logic [N_DEST-1:0] dest_ff;
	logic [N_PIN-1:0]  pin_irq_ff;
	logic [2*N_PIN-1:0] prio_ff;
	logic              irq_ff;

	// address decode
	wire               sel_range = (ADDR_I < 6'(N_SRC));
	wire [4:0]         sel_idx   = ADDR_I[4:0];
	wire [N_SRC-1:0]   src_here  = {{2{BIG_FLASH}}, {4{BIG_PKG}}, {SEL_TAU1_LO{1'b1}}}; // RULE10 RULE11
	wire               sel_live  = sel_range && src_here[sel_idx];
	wire               wr_sel    = WR_I && sel_live;
	wire               wr_mask   = WR_I && hit(OFS_MASK);
	wire               wr_req    = WR_I && hit(OFS_REQ);
	wire               wr_prio1  = WR_I && hit(OFS_PRIO1);
	wire               wr_prio0  = WR_I && hit(OFS_PRIO0);
	wire               wr_rise   = WR_I && hit(OFS_RISE);
	wire               wr_fall   = WR_I && hit(OFS_FALL);
	wire               wr_clr    = WR_I && hit(OFS_CLR);
	wire               wr_ien    = WR_I && hit(OFS_IEN);
	// the top code bit only exists on the large package
	wire [CODE_W-1:0]  sel_wdata = {BIG_PKG & WDATA_I[3], WDATA_I[2:0]}; // RULE10

	// pin edge detection: a level counts once the second and third stages agree
	wire [N_PIN-1:0]   stable    = ~(s2_ff ^ s3_ff);
	wire [N_PIN-1:0]   rise      = {N_PIN{primed_ff}} & stable & s3_ff & ~lvl_ff;
	wire [N_PIN-1:0]   fall      = {N_PIN{primed_ff}} & stable & ~s3_ff & lvl_ff;
	wire [N_PIN-1:0]   pin_evt   = (rise & rise_en_ff[N_PIN-1:0]) |
		(fall & fall_en_ff[N_PIN-1:0]); // RULE4
	wire [N_SRC-1:0]   src_evt   = {ONCHIP_EVT_I, pin_evt} & src_here; // RULE8 RULE9

	// routing matrix
	logic [N_DEST-1:0] route;
	logic              drop;
	always_comb begin
		route = '0;
		drop  = 1'b0;
		for (int i = 0; i < N_SRC; i++) begin
			if (src_evt[i]) begin
				if (code_valid(sel_ff[i])) begin // RULE6 RULE12 RULE13 RULE14 RULE15 RULE16
					route[sel_ff[i] - 4'h1] = 1'b1;
				end else if (sel_ff[i] != DST_OFF) begin // RULE5 RULE19
					drop = 1'b1;
				end
			end
		end
	end

	// interrupt status: set wins over a clear in the same cycle
	wire [N_STS-1:0]   sts_set   = {drop, |route, |pin_evt};
	wire [N_STS-1:0]   sts_clr   = wr_clr ? WDATA_I[N_STS-1:0] : '0;
	wire [N_STS-1:0]   nxt_sts   = (sts_ff & ~sts_clr) | sts_set;

	// pin request flags sit at bits 2..7; hardware set beats a software write
	wire [DATA_W-1:0]  req_set   = {pin_evt, {PIN_BIT0{1'b0}}};
	wire [DATA_W-1:0]  nxt_req   = (wr_req ? WDATA_I : req_ff) | req_set; // RULE2

	wire [N_PIN-1:0]   nxt_pin_irq = req_ff[DATA_W-1:PIN_BIT0] & ~mask_ff[DATA_W-1:PIN_BIT0]; // RULE1
	logic [2*N_PIN-1:0] nxt_prio;
	always_comb begin
		nxt_prio = '0;
		for (int n = 0; n < N_PIN; n++) begin
			nxt_prio[2*n +: 2] = {prio1_ff[PIN_BIT0+n], prio0_ff[PIN_BIT0+n]}; // RULE3
		end
	end

	// read mux
	logic [DATA_W-1:0] rd_mux;
	always_comb begin
		rd_mux = '0;
		if (sel_live) begin
			rd_mux = {4'h0, sel_ff[sel_idx]}; // RULE7
		end else if (hit(OFS_MASK)) begin
			rd_mux = mask_ff;
		end else if (hit(OFS_REQ)) begin
			rd_mux = req_ff;
		end else if (hit(OFS_PRIO1)) begin
			rd_mux = prio1_ff;
		end else if (hit(OFS_PRIO0)) begin
			rd_mux = prio0_ff;
		end else if (hit(OFS_RISE)) begin
			rd_mux = rise_en_ff;
		end else if (hit(OFS_FALL)) begin
			rd_mux = fall_en_ff;
		end else if (hit(OFS_STS)) begin
			rd_mux = {5'h00, sts_ff};
		end else if (hit(OFS_IEN)) begin
			rd_mux = {5'h00, ien_ff};
		end
	end

	always_ff @(posedge CLK_I) begin
		for (int i = 0; i < N_SRC; i++) begin
			if (!RSTN_I) begin
				sel_ff[i] <= RST_SEL;
			end else if (wr_sel && (sel_idx == 5'(i))) begin
				sel_ff[i] <= sel_wdata; // RULE6
			end
		end
	end

	always_ff @(posedge CLK_I) begin
		if (!RSTN_I) begin
			mask_ff    <= RST_MASK;
			req_ff     <= RST_REQ;
			prio1_ff   <= RST_PRIO;
			prio0_ff   <= RST_PRIO;
			rise_en_ff <= RST_EDGE;
			fall_en_ff <= RST_EDGE;
		end else begin
			req_ff <= nxt_req;
			if (wr_mask) begin
				mask_ff <= WDATA_I;
			end
			if (wr_prio1) begin
				prio1_ff <= WDATA_I;
			end
			if (wr_prio0) begin
				prio0_ff <= WDATA_I;
			end
			if (wr_rise) begin
				rise_en_ff <= WDATA_I;
			end
			if (wr_fall) begin
				fall_en_ff <= WDATA_I;
			end
		end
	end

	// primed_ff only holds off edges until the first clock after reset, so a pin that is high at reset still fakes a rising edge
	always_ff @(posedge CLK_I) begin
		if (!RSTN_I) begin
			s1_ff     <= '0;
			s2_ff     <= '0;
			s3_ff     <= '0;
			lvl_ff    <= '0;
			primed_ff <= 1'b0;
		end else begin
			s1_ff <= EXT_PIN_I;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			for (int n = 0; n < N_PIN; n++) begin
				if (stable[n]) begin
					lvl_ff[n] <= s3_ff[n];
				end
			end
			primed_ff <= primed_ff | (&stable);
		end
	end

	always_ff @(posedge CLK_I) begin
		if (!RSTN_I) begin
			sts_ff     <= RST_STS;
			ien_ff     <= RST_STS;
			rdata_ff   <= '0;
			dest_ff    <= '0;
			pin_irq_ff <= '0;
			prio_ff    <= '0;
			irq_ff     <= 1'b0;
		end else begin
			sts_ff     <= nxt_sts;
			if (wr_ien) begin
				ien_ff <= WDATA_I[N_STS-1:0];
			end
			rdata_ff   <= RD_I ? rd_mux : '0;
			dest_ff    <= route; // RULE19
			pin_irq_ff <= nxt_pin_irq;
			prio_ff    <= nxt_prio;
			irq_ff     <= |(sts_ff & ien_ff);
		end
	end

	assign RDATA_O    = rdata_ff;
	assign DEST_EVT_O = dest_ff;
	assign PIN_IRQ_O  = pin_irq_ff;
	assign PIN_PRIO_O = prio_ff;
	assign IRQ_O      = irq_ff;
endmodule

/* sim/elr_evt_src.sv */
// partner: on-chip event sources and destination pulse counters
`timescale 1ns/1ps
module elr_evt_src (
	input  wire logic                         clk_i,
	input  wire logic [elr_pkg::N_ONCHIP-1:0] fire_i,
	input  wire logic [elr_pkg::N_DEST-1:0]   dest_i,
	output logic      [elr_pkg::N_ONCHIP-1:0] evt_o,
	output int                                cnt_o [elr_pkg::N_DEST]
);
	import elr_pkg::*;
	// declaration values keep the sources quiet and counters known before the first edge
	logic [N_ONCHIP-1:0] evt_ff = '0;
	int                  cnt_ff [N_DEST] = '{default: 0};
	// sources pulse for exactly one clock, like the real same-clock generators
	always @(posedge clk_i) begin
		evt_ff <= fire_i;
		for (int k = 0; k < N_DEST; k++) cnt_ff[k] <= cnt_ff[k] + int'(dest_i[k]);
	end
	assign evt_o = evt_ff;
	assign cnt_o = cnt_ff;
endmodule

/* sim/elr_router_monitor.sv */
// checker: port-level assertions for the event link router
`timescale 1ns/1ps
module elr_router_monitor (
	input wire logic                          CLK_I,
	input wire logic                          RSTN_I,
	input wire logic [elr_pkg::ADDR_W-1:0]    ADDR_I,
	input wire logic [elr_pkg::DATA_W-1:0]    WDATA_I,
	input wire logic                          WR_I,
	input wire logic                          RD_I,
	input wire logic [elr_pkg::DATA_W-1:0]    RDATA_O,
	input wire logic [elr_pkg::N_PIN-1:0]     EXT_PIN_I,
	input wire logic [elr_pkg::N_ONCHIP-1:0]  ONCHIP_EVT_I,
	input wire logic [elr_pkg::N_DEST-1:0]    DEST_EVT_O,
	input wire logic [elr_pkg::N_PIN-1:0]     PIN_IRQ_O,
	input wire logic [2*elr_pkg::N_PIN-1:0]   PIN_PRIO_O
);
	import elr_pkg::*;
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RSTN_I);
	property p_rd_idle; !$past(RD_I) |-> RDATA_O == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");
	property p_rd_upper; RD_I && ADDR_I < 6'h1A |=> RDATA_O[7:4] == 4'h0; endproperty
	a_rd_upper: assert property (p_rd_upper) else $error("select upper bits not zero");
	property p_rd_void; RD_I && (ADDR_I == OFS_CLR || ADDR_I > OFS_IEN) |=> RDATA_O == 8'h00; endproperty
	a_rd_void: assert property (p_rd_void) else $error("void address read not zero");
	// a pin edge reaches a destination a few cycles after the pin moved
	property p_dest_cause; DEST_EVT_O != 0 |-> $past(ONCHIP_EVT_I) != 0 ||
		$past(EXT_PIN_I, 2) != $past(EXT_PIN_I, 8); endproperty
	a_dest_cause: assert property (p_dest_cause) else $error("pulse without event");
	property p_pin_irq_cause; (PIN_IRQ_O & ~$past(PIN_IRQ_O)) != 0 |-> $past(WR_I) ||
		$past(WR_I, 2) || $past(EXT_PIN_I, 2) != $past(EXT_PIN_I, 9); endproperty
	a_pin_irq_cause: assert property (p_pin_irq_cause) else $error("pin irq rose");
	property p_pin_irq_drop; (~PIN_IRQ_O & $past(PIN_IRQ_O)) != 0 |-> $past(WR_I) || $past(WR_I, 2);
	endproperty
	a_pin_irq_drop: assert property (p_pin_irq_drop) else $error("pin irq fell");
	property p_prio_hi; WR_I && ADDR_I == OFS_PRIO1 |-> ##2 PIN_PRIO_O[1] == $past(WDATA_I[2], 2);
	endproperty
	a_prio_hi: assert property (p_prio_hi) else $error("priority high bit wrong");
	property p_prio_lo; WR_I && ADDR_I == OFS_PRIO0 |-> ##2 PIN_PRIO_O[0] == $past(WDATA_I[2], 2);
	endproperty
	a_prio_lo: assert property (p_prio_lo) else $error("priority low bit wrong");
endmodule
bind elr_router elr_router_monitor u_elr_router_monitor (.CLK_I(CLK_I), .RSTN_I(RSTN_I),
	.ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
	.EXT_PIN_I(EXT_PIN_I), .ONCHIP_EVT_I(ONCHIP_EVT_I), .DEST_EVT_O(DEST_EVT_O),
	.PIN_IRQ_O(PIN_IRQ_O), .PIN_PRIO_O(PIN_PRIO_O));

/* sim/elr_router_tb.sv */
// bench: registers, routing codes, pin front end and interrupt
`timescale 1ns/1ps
module elr_router_tb;
	import elr_pkg::*;
	logic                clk = 0, rstn = 0, wr = 0, rd = 0, irq;
	logic [ADDR_W-1:0]   addr = 0;
	logic [DATA_W-1:0]   wdat = 0, rdat;
	logic [N_PIN-1:0]    pin = 0, pirq;
	logic [N_ONCHIP-1:0] fire = 0, evt;
	logic [N_DEST-1:0]   dst;
	logic [2*N_PIN-1:0]  prio;
	logic [3:0]          c;
	logic [ADDR_W-1:0]   ra [10] = '{OFS_MASK, OFS_REQ, OFS_PRIO1, OFS_PRIO0, OFS_RISE,
		OFS_FALL, OFS_STS, OFS_SEL_BASE, OFS_CLR, 6'h3F};
	logic [DATA_W-1:0]   rv [10] = '{RST_MASK, RST_REQ, RST_PRIO, RST_PRIO, RST_EDGE,
		RST_EDGE, 8'h00, 8'h00, 8'h00, 8'h00};
	int                  cnt [N_DEST], prev [N_DEST];
	int                  fails = 0, compares = 0;
	always #2.5 clk = ~clk;
	elr_router u_elr_router (.CLK_I(clk), .RSTN_I(rstn), .ADDR_I(addr), .WDATA_I(wdat),
		.WR_I(wr), .RD_I(rd), .RDATA_O(rdat), .EXT_PIN_I(pin), .ONCHIP_EVT_I(evt),
		.DEST_EVT_O(dst), .PIN_IRQ_O(pirq), .PIN_PRIO_O(prio), .IRQ_O(irq));
	elr_evt_src u_elr_evt_src (.clk_i(clk), .fire_i(fire),
		.dest_i(dst), .evt_o(evt), .cnt_o(cnt));
	function automatic int dexp(input logic [3:0] code);
		return (code >= 4'h1 && code <= 4'h9) ? int'(code) - 1 : -1;
	endfunction
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("mismatch %0t got %0h exp %0h", $time, got, exp);
		end
	endtask
	task wreg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk);
		addr <= a;
		wdat <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdat, e);
	endtask
	task pulse(input int i);
		@(posedge clk);
		fire[i] <= 1'b1;
		@(posedge clk);
		fire <= '0;
		repeat (3) @(posedge clk);
	endtask
	task test_done;
		if (fails == 0 && compares > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		void'($urandom(8741));
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		wreg(6'h3F, 8'hA5);
		foreach (ra[j]) rchk(ra[j], rv[j]);
		// every code once, then random codes; upper nibble written with noise
		for (int i = 0; i < N_ONCHIP; i++) begin
			c = (i < 16) ? 4'(i) : 4'($urandom_range(15));
			wreg(OFS_SEL_BASE + 6'(N_PIN + i), {4'($urandom), c});
			rchk(OFS_SEL_BASE + 6'(N_PIN + i), {4'h0, c});
			prev = cnt;
			pulse(i);
			for (int k = 0; k < N_DEST; k++) chk(cnt[k] - prev[k], k == dexp(c));
		end
		wreg(OFS_MASK, 8'hFF);
		wreg(OFS_REQ, 8'h00);
		wreg(OFS_PRIO1, 8'hFF);
		wreg(OFS_PRIO0, 8'hFF);
		wreg(OFS_RISE, 8'h01);
		wreg(OFS_FALL, 8'h00);
		wreg(OFS_SEL_BASE, {4'h0, DST_TIMER_ARRAY_UNIT});
		wreg(OFS_SEL_BASE + 6'd16, {4'h0, DST_ADC});
		prev = cnt;
		@(posedge clk);
		pin[0] <= 1'b1;
		repeat (10) @(posedge clk);
		pulse(10);
		chk(cnt[1] - prev[1], 1);
		chk(cnt[0] - prev[0], 1);
		rchk(OFS_REQ, 8'h04);
		chk(pirq[0], 1'b0);
		wreg(OFS_MASK, 8'hFB);
		repeat (2) @(posedge clk);
		chk(pirq[0], 1'b1);
		wreg(OFS_REQ, 8'h00);
		rchk(OFS_REQ, 8'h00);
		chk(pirq[0], 1'b0);
		// pin alternates, so each edge mode sees both a fall and a rise
		for (int m = 0; m < 8; m++) begin
			wreg(OFS_RISE, {7'h0, m[1]});
			wreg(OFS_FALL, {7'h0, m[2]});
			prev = cnt;
			@(posedge clk);
			pin[0] <= ~pin[0];
			repeat (10) @(posedge clk);
			chk(cnt[1] - prev[1], pin[0] ? m[1] : m[2]);
		end
		for (int p = 0; p < 4; p++) begin
			wreg(OFS_PRIO1, {5'h0, p[1], 2'h0});
			wreg(OFS_PRIO0, {5'h0, p[0], 2'h0});
			repeat (2) @(posedge clk);
			chk(prio[1:0], p[1:0]);
		end
		wreg(OFS_CLR, 8'h07);
		wreg(OFS_IEN, 8'h02);
		pulse(1);
		chk(irq, 1'b1);
		wreg(OFS_STS, 8'h00);
		rchk(OFS_STS, 8'h02);
		wreg(OFS_CLR, 8'h02);
		pulse(13);
		chk(irq, 1'b0);
		rchk(OFS_STS, 8'h04);
		test_done();
	end
endmodule
